/* rtl/vls_map.svh */
`ifndef VLS_MAP_SVH
`define VLS_MAP_SVH
// ---------------------------------------------
// Command codes
// ---------------------------------------------
`define VLS_CMD_UPPER_LIMIT 8'h24
`define VLS_CMD_MARGIN_UP 8'h25
`define VLS_CMD_MARGIN_DOWN 8'h26
`define VLS_CMD_SLEW_RATE 8'h27
// ---------------------------------------------
// Slew rate fields and reset
// ---------------------------------------------
`define VLS_SLEW_EXP_HI 15
`define VLS_SLEW_EXP_LO 11
`define VLS_SLEW_MAN_HI 10
`define VLS_SLEW_MAN_LO 0
`define VLS_SLEW_EXP_RESET 5'h1C
`define VLS_SLEW_MAN_RESET 11'h010
// Valid range in micro-mV/us: 0.067 and 15.933 mV/us
`define VLS_SLEW_MIN_UMVUS 32'd67000
`define VLS_SLEW_MAX_UMVUS 32'd15933000
// One mantissa step at exponent 0 in micro-mV/us
`define VLS_SLEW_UNIT_UMVUS 32'd1000000
// Micro-mV in one volt, and half of it for rounding
`define VLS_UMV_PER_VOLT 64'd1000000000
`define VLS_UMV_HALF_VOLT 64'd500000000
// ---------------------------------------------
// Voltage format exponent range
// ---------------------------------------------
`define VLS_VFMT_EXP_MAX 5'h1C
`define VLS_VFMT_EXP_MIN 5'h14
// ---------------------------------------------
// Rate divider: one slew tick each microsecond
// ---------------------------------------------
`define VLS_CLK_MHZ 100
`define VLS_TICK_CYCLES 7'd100
`endif

/* rtl/vls_pkg.sv */
package vls_pkg;
	typedef enum logic [1:0] {
		VLS_MARGIN_OFF,
		VLS_MARGIN_LOW,
		VLS_MARGIN_HIGH,
		VLS_MARGIN_RSVD
	} vls_margin_t;
	typedef enum logic [1:0] {
		VLS_HOLD,
		VLS_RAMP,
		VLS_JUMP
	} vls_state_t;
endpackage : vls_pkg

/* rtl/vls_rate_div.sv */
`timescale 1ns/100ps
`include "vls_map.svh"
module vls_rate_div (
	input wire logic core_clk,
	input wire logic rst,
	output logic tick
);
	logic [6:0] count;
	// ---------------------------------------------
	// One-cycle enable every microsecond
	// ---------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			count <= 7'h00;
			tick <= 1'b0;
		end else if (count == `VLS_TICK_CYCLES - 7'd1) begin
			count <= 7'h00;
			tick <= 1'b1;
		end else begin
			count <= count + 7'd1;
			tick <= 1'b0;
		end
	end
endmodule : vls_rate_div

/* rtl/vls_slew_step.sv */
`timescale 1ns/100ps
`include "vls_map.svh"
module vls_slew_step #(
	parameter int VW = 16
) (
	input wire logic [15:0] slewRate,
	input wire logic [4:0] voltExp,
	output logic [VW-1:0] step,
	output logic rateValid
);
	logic signed [4:0] se;
	logic signed [10:0] sm;
	logic signed [5:0] shift;
	logic [31:0] mag;
	logic [63:0] umv;
	if (VW < 2 || VW > 32) begin : g_vw_check
		$error("vls_slew_step needs a width of 2 to 32");
	end
	// ---------------------------------------------
	// Decode linear11 rate, convert to voltage codes
	// ---------------------------------------------
	always_comb begin
		se = slewRate[`VLS_SLEW_EXP_HI:`VLS_SLEW_EXP_LO];
		sm = slewRate[`VLS_SLEW_MAN_HI:`VLS_SLEW_MAN_LO];
		mag = (sm[10]) ? 32'h0 : {21'h0, sm};
		if (se < 0)
			umv = ({32'h0, mag} * {32'h0, `VLS_SLEW_UNIT_UMVUS}) >> (-se);
		else
			umv = ({32'h0, mag} * {32'h0, `VLS_SLEW_UNIT_UMVUS}) << se;
		rateValid = (umv >= {32'h0, `VLS_SLEW_MIN_UMVUS})
			&& (umv <= {32'h0, `VLS_SLEW_MAX_UMVUS});
		// Codes per us: rate in V/us times 2^-voltExp, rounded to nearest
		shift = 6'sd0 - {voltExp[4], voltExp};
		umv = (umv << shift) + `VLS_UMV_HALF_VOLT;
		umv = umv / `VLS_UMV_PER_VOLT;
		if (umv == 64'h0)
			step = {{(VW-1){1'b0}}, 1'b1};
		else if (umv > {{(64-VW){1'b0}}, {VW{1'b1}}})
			step = {VW{1'b1}};
		else
			step = umv[VW-1:0];
	end
endmodule : vls_slew_step

/* rtl/vls_limit_slew.sv */
`timescale 1ns/100ps
`include "vls_map.svh"
module vls_limit_slew
	import vls_pkg::*;
#(
	parameter int VW = 16
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	input wire logic [7:0] cmdCode,
	input wire logic [15:0] wrData,
	output logic [15:0] rdData,
	output logic rdHit,
	input wire logic bootLoad,
	input wire logic [15:0] bootUpperLimit,
	input wire logic [15:0] bootMarginUp,
	input wire logic [15:0] bootMarginDown,
	input wire logic [10:0] bootSlewMantissa,
	input wire logic [4:0] voltageFormatSelect,
	input wire logic marginRelative,
	input wire logic [15:0] outputSetpoint,
	input wire logic [15:0] outputOffset,
	input wire logic [1:0] marginSelect,
	input wire logic conversionEnable,
	output logic [15:0] targetNow,
	output logic [15:0] targetGoal,
	output logic ramping,
	output logic limitWarnPulse,
	output logic noneOfAboveSet,
	output logic statusWordVoutSet,
	output logic voutMaxMinWarnSet,
	output logic invalidDataPulse,
	output logic alertRequest,
	input wire logic alertClear
);
	if (VW != 16) begin : g_vw_check
		$error("vls_limit_slew serves only a 16-bit target");
	end
	logic [15:0] outputUpperLimit;
	logic [15:0] marginUpTarget;
	logic [15:0] marginDownTarget;
	logic [15:0] targetSlewRate;
	logic [15:0] step;
	logic rateValid;
	logic tick;
	logic [16:0] candidate;
	logic [15:0] source;
	logic overLimit;
	logic [15:0] next_goal;
	logic wasEnabled;
	logic [15:0] lastGoal;
	logic [16:0] lastCandidate;
	logic [16:0] muSum;
	logic muValid;
	logic mdValid;
	logic srValid;
	logic [16:0] stepped;
	logic fmtOk;
	vls_state_t state;
	vls_margin_t marginMode;

	vls_rate_div u_div (
		.core_clk(core_clk),
		.rst(rst),
		.tick(tick)
	);
	vls_slew_step #(.VW(16)) u_step (
		.slewRate(targetSlewRate),
		.voltExp(voltageFormatSelect),
		.step(step),
		.rateValid(rateValid)
	);
	vls_slew_step #(.VW(16)) u_chk (
		.slewRate(wrData),
		.voltExp(voltageFormatSelect),
		.step(),
		.rateValid(srValid)
	);

	// ---------------------------------------------
	// Target selection and limit compare
	// ---------------------------------------------
	always_comb begin
		marginMode = vls_margin_t'(marginSelect);
		unique case (marginMode)
			VLS_MARGIN_HIGH: source = marginUpTarget;
			VLS_MARGIN_LOW: source = marginDownTarget;
			default: source = outputSetpoint;
		endcase
		// Relative margins are taken as offsets from the setpoint
		if (marginRelative && marginMode inside {VLS_MARGIN_HIGH,
			VLS_MARGIN_LOW})
			candidate = {1'b0, outputSetpoint} + {1'b0, source}
				+ {outputOffset[15], outputOffset};
		else
			candidate = {1'b0, source}
				+ {outputOffset[15], outputOffset};
		if (candidate[16] && outputOffset[15] && source < 16'h8000)
			candidate = 17'h0;
		overLimit = candidate > {1'b0, outputUpperLimit};
		next_goal = overLimit ? outputUpperLimit : candidate[15:0];
		fmtOk = ($signed(voltageFormatSelect) <= $signed(`VLS_VFMT_EXP_MAX))
			&& ($signed(voltageFormatSelect)
			>= $signed(`VLS_VFMT_EXP_MIN));
	end

	// Write validation for margin commands; slew rate is checked by u_chk
	always_comb begin
		muSum = {1'b0, wrData} + {outputOffset[15], outputOffset};
		muValid = fmtOk && (marginRelative
			|| muSum <= {1'b0, outputUpperLimit});
		mdValid = fmtOk && (marginRelative
			|| wrData <= outputUpperLimit);
	end

	// ---------------------------------------------
	// Register writes, boot load
	// ---------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			outputUpperLimit <= 16'h0000;
			marginUpTarget <= 16'h0000;
			marginDownTarget <= 16'h0000;
			targetSlewRate <= {`VLS_SLEW_EXP_RESET,
				`VLS_SLEW_MAN_RESET};
			invalidDataPulse <= 1'b0;
		end else begin
			invalidDataPulse <= 1'b0;
			if (bootLoad) begin
				outputUpperLimit <= bootUpperLimit;
				marginUpTarget <= bootMarginUp;
				marginDownTarget <= bootMarginDown;
				targetSlewRate <= {`VLS_SLEW_EXP_RESET,
					bootSlewMantissa};
			end else if (wrStrobe) begin
				unique case (cmdCode)
					`VLS_CMD_UPPER_LIMIT: outputUpperLimit <= wrData;
					`VLS_CMD_MARGIN_UP: begin
						if (muValid)
							marginUpTarget <= wrData;
						else
							invalidDataPulse <= 1'b1;
					end
					`VLS_CMD_MARGIN_DOWN: begin
						if (mdValid)
							marginDownTarget <= wrData;
						else
							invalidDataPulse <= 1'b1;
					end
					`VLS_CMD_SLEW_RATE: begin
						if (srValid)
							targetSlewRate <= wrData;
						else
							invalidDataPulse <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	// ---------------------------------------------
	// Read back
	// ---------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdData <= 16'h0000;
		end else if (rdStrobe) begin
			unique case (cmdCode)
				`VLS_CMD_UPPER_LIMIT: rdData <= outputUpperLimit;
				`VLS_CMD_MARGIN_UP: rdData <= marginUpTarget;
				`VLS_CMD_MARGIN_DOWN: rdData <= marginDownTarget;
				`VLS_CMD_SLEW_RATE: rdData <= targetSlewRate;
				default: rdData <= 16'h0000;
			endcase
		end
	end
	always_comb begin
		rdHit = cmdCode inside {`VLS_CMD_UPPER_LIMIT, `VLS_CMD_MARGIN_UP,
			`VLS_CMD_MARGIN_DOWN, `VLS_CMD_SLEW_RATE};
	end

	// ---------------------------------------------
	// Clamp warning, one per new clamped goal or new over-limit target
	// ---------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			lastGoal <= 16'h0000;
			lastCandidate <= 17'h00000;
			limitWarnPulse <= 1'b0;
			wasEnabled <= 1'b0;
		end else begin
			wasEnabled <= conversionEnable;
			lastGoal <= next_goal;
			lastCandidate <= candidate;
			// Once per new target or lowered limit, never every cycle
			limitWarnPulse <= conversionEnable && overLimit
				&& (next_goal != lastGoal || !wasEnabled
				|| candidate != lastCandidate);
		end
	end

	// Status bits: the set wins over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			noneOfAboveSet <= 1'b0;
			statusWordVoutSet <= 1'b0;
			voutMaxMinWarnSet <= 1'b0;
			alertRequest <= 1'b0;
		end else if (limitWarnPulse || invalidDataPulse) begin
			if (limitWarnPulse) begin
				noneOfAboveSet <= 1'b1;
				statusWordVoutSet <= 1'b1;
				voutMaxMinWarnSet <= 1'b1;
			end
			alertRequest <= 1'b1;
		end else if (alertClear) begin
			noneOfAboveSet <= 1'b0;
			statusWordVoutSet <= 1'b0;
			voutMaxMinWarnSet <= 1'b0;
			alertRequest <= 1'b0;
		end
	end

	// ---------------------------------------------
	// Output ramp
	// ---------------------------------------------
	always_comb begin
		if (targetNow < targetGoal)
			stepped = {1'b0, targetNow} + {1'b0, step};
		else
			stepped = {1'b0, targetNow} - {1'b0, step};
		ramping = state == VLS_RAMP;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= VLS_HOLD;
			targetGoal <= 16'h0000;
			targetNow <= 16'h0000;
		end else begin
			targetGoal <= next_goal;
			unique case (state)
				VLS_HOLD: begin
					// Turn on and off bypass the programmed rate
					if (conversionEnable != wasEnabled)
						state <= VLS_JUMP;
					else if (conversionEnable && targetNow != targetGoal)
						state <= VLS_RAMP;
				end
				VLS_RAMP: begin
					if (!conversionEnable)
						state <= VLS_JUMP;
					else if (targetNow == targetGoal)
						state <= VLS_HOLD;
					else if (tick) begin
						if ((targetNow < targetGoal
							&& stepped >= {1'b0, targetGoal})
							|| (targetNow > targetGoal
							&& (stepped[16]
							|| stepped <= {1'b0, targetGoal})))
							targetNow <= targetGoal;
						else
							targetNow <= stepped[15:0];
					end
				end
				VLS_JUMP: begin
					// Soft start/stop sequencing lies outside this block
					targetNow <= conversionEnable ? targetGoal : 16'h0000;
					state <= VLS_HOLD;
				end
				default: state <= VLS_HOLD;
			endcase
		end
	end
endmodule : vls_limit_slew

/* tb/vls_limit_slew_asserts.sv */
`timescale 1ns/100ps
module vls_limit_slew_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	input wire logic [7:0] cmdCode,
	input wire logic [15:0] wrData,
	input wire logic bootLoad,
	input wire logic [15:0] bootUpperLimit,
	input wire logic conversionEnable,
	input wire logic [15:0] rdData,
	input wire logic rdHit,
	input wire logic [15:0] targetNow,
	input wire logic [15:0] targetGoal,
	input wire logic limitWarnPulse,
	input wire logic invalidDataPulse,
	input wire logic noneOfAboveSet,
	input wire logic statusWordVoutSet,
	input wire logic voutMaxMinWarnSet,
	input wire logic alertRequest
);
	logic [15:0] lim;
	// Shadow limit, boot wins over a write
	always_ff @(posedge core_clk) begin
		if (rst)
			lim <= 16'h0000;
		else if (bootLoad)
			lim <= bootUpperLimit;
		else if (wrStrobe && cmdCode == 8'h24)
			lim <= wrData;
	end
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (rst);
	a_hit_decode: assert property (
		rdHit == (cmdCode >= 8'h24 && cmdCode <= 8'h27))
		else $error("rdHit decode wrong");
	a_read_other: assert property (
		rdStrobe && !rdHit |=> rdData == 16'h0000)
		else $error("foreign read not zero");
	a_read_hold: assert property (
		!rdStrobe |=> $stable(rdData))
		else $error("rdData moved without read");
	a_warn_sticky: assert property (
		limitWarnPulse |=> voutMaxMinWarnSet && noneOfAboveSet
			&& statusWordVoutSet && alertRequest)
		else $error("warning bits not set");
	a_bad_alert: assert property (
		invalidDataPulse |=> alertRequest)
		else $error("invalid data not alerted");
	a_bad_cause: assert property (
		invalidDataPulse |-> $past(wrStrobe)
			&& $past(cmdCode) inside {[8'h25:8'h27]})
		else $error("invalid pulse without write");
	a_goal_limit: assert property (
		conversionEnable ##1 conversionEnable |-> targetGoal <= $past(lim))
		else $error("goal above limit");
	a_ramp_slow: assert property (
		$changed(targetNow) && conversionEnable && $past(conversionEnable)
		|=> ($stable(targetNow) || !conversionEnable
			|| $changed(conversionEnable))[*8])
		else $error("target moved faster than tick");
	a_off_zero: assert property (
		$fell(conversionEnable) |-> ##[1:3] targetNow == 16'h0000)
		else $error("turn off not immediate");
	a_on_jump: assert property (
		$rose(conversionEnable) |-> ##[1:3] targetNow == targetGoal)
		else $error("turn on not immediate");
	a_alert_cause: assert property (
		$rose(alertRequest) |-> $past(limitWarnPulse || invalidDataPulse))
		else $error("alert without cause");
	c_warn: cover property (limitWarnPulse);
	c_bad: cover property (invalidDataPulse);
	c_off: cover property ($fell(conversionEnable));
endmodule : vls_limit_slew_chk
bind vls_limit_slew vls_limit_slew_chk vls_limit_slew_chk_i (
	.core_clk, .rst, .wrStrobe, .rdStrobe, .cmdCode, .wrData, .bootLoad,
	.bootUpperLimit, .conversionEnable, .rdData, .rdHit, .targetNow,
	.targetGoal, .limitWarnPulse, .invalidDataPulse, .noneOfAboveSet,
	.statusWordVoutSet, .voutMaxMinWarnSet, .alertRequest
);

/* tb/vls_host_model.sv */
`timescale 1ns/100ps
module vls_host_model (
	input wire logic core_clk,
	output logic wrStrobe,
	output logic rdStrobe,
	output logic [7:0] cmdCode,
	output logic [15:0] wrData
);
	initial begin
		wrStrobe = 1'b0;
		rdStrobe = 1'b0;
		cmdCode = 8'h00;
		wrData = 16'h0000;
	end
	// Released lines show the inverse, never the stale word
	task automatic xfer(input logic w, input logic [7:0] c,
		input logic [15:0] d, input int idle);
		repeat (idle) @(posedge core_clk);
		@(posedge core_clk);
		wrStrobe <= w;
		rdStrobe <= !w;
		cmdCode <= c;
		wrData <= d;
		@(posedge core_clk);
		wrStrobe <= 1'b0;
		rdStrobe <= 1'b0;
		cmdCode <= ~c;
		wrData <= ~d;
	endtask : xfer
endmodule : vls_host_model

/* tb/tb_vls_limit_slew.sv */
`timescale 1ns/100ps
module tb_vls_limit_slew;
	import vls_pkg::*;
	logic core_clk = 1'b0, rst = 1'b1, bootLoad = 1'b0, alertClear = 1'b0;
	logic marginRelative = 1'b0, conversionEnable = 1'b0;
	logic wrStrobe, rdStrobe, rdHit, ramping, limitWarnPulse, alertRequest;
	logic noneOfAboveSet, statusWordVoutSet, voutMaxMinWarnSet;
	logic invalidDataPulse, rdPend = 1'b0;
	logic [7:0] cmdCode;
	logic [15:0] wrData, rdData, targetNow, targetGoal;
	logic [15:0] bootUpperLimit = 16'h0, bootMarginUp = 16'h0;
	logic [15:0] bootMarginDown = 16'h0, outputSetpoint = 16'h0;
	logic [15:0] outputOffset = 16'h0;
	logic [10:0] bootSlewMantissa = 11'h0;
	logic [4:0] voltageFormatSelect = 5'h17;
	logic [1:0] marginSelect = 2'h0;
	logic [31:0] seed = 32'd87;
	logic [15:0] expQ[$];
	int failures = 0, n_tests = 0;
	vls_host_model vls_host_model_i (.core_clk, .wrStrobe, .rdStrobe,
		.cmdCode, .wrData);
	vls_limit_slew vls_limit_slew_i (.core_clk, .rst, .wrStrobe,
		.rdStrobe, .cmdCode, .wrData, .rdData, .rdHit, .bootLoad,
		.bootUpperLimit, .bootMarginUp, .bootMarginDown, .bootSlewMantissa,
		.voltageFormatSelect, .marginRelative, .outputSetpoint, .outputOffset,
		.marginSelect, .conversionEnable, .targetNow, .targetGoal, .ramping,
		.limitWarnPulse, .noneOfAboveSet, .statusWordVoutSet,
		.voutMaxMinWarnSet, .invalidDataPulse, .alertRequest, .alertClear);
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("mismatch word exp %h got %h", e, g);
		end
	endtask : chk
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		vls_host_model_i.xfer(1'b1, c, d, 0);
	endtask : wr
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		expQ.push_back(e);
		vls_host_model_i.xfer(1'b0, c, 16'h0000, int'(xs() % 3));
	endtask : rd
	task automatic tk();
		@(posedge core_clk);
		#1;
	endtask : tk
	// Read answers land one edge after the strobe
	always @(posedge core_clk) rdPend <= rdStrobe;
	always @(negedge core_clk) begin
		if (rdPend === 1'b1)
			chk(expQ.pop_front(), rdData);
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		close_out();
	end
	initial begin
		logic [15:0] m;
		static logic [24:0] tab[8] = '{25'h027E0FE, 25'h127E001, 25'h127E0FF,
			25'h127E7FF, 25'h12503F8, 25'h02503F0, 25'h1260401, 25'h0260100};
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rd(8'h27, 16'hE010);
		rd(8'h28, 16'h0000);
		@(posedge core_clk);
		bootLoad <= 1'b1;
		bootUpperLimit <= 16'h0400;
		bootMarginUp <= 16'h0300;
		bootSlewMantissa <= 11'h0A0;
		@(posedge core_clk);
		bootLoad <= 1'b0;
		rd(8'h24, 16'h0400);
		rd(8'h27, 16'hE0A0);
		$display("test reset_boot done");
		for (int i = 0; i < 6; i++) begin
			m = 16'(2 + xs() % 253);
			wr(8'h27, 16'hE000 | m);
			rd(8'h27, 16'hE000 | m);
		end
		outputOffset <= 16'h0010;
		foreach (tab[i]) begin
			wr(tab[i][23:16], tab[i][15:0]);
			#1 chk(16'(tab[i][24]), 16'(invalidDataPulse));
		end
		rd(8'h27, 16'hE0FE);
		rd(8'h25, 16'h03F0);
		rd(8'h26, 16'h0100);
		wr(8'h27, 16'hE0A0);
		$display("test validity done");
		@(posedge core_clk);
		outputSetpoint <= 16'h0200;
		conversionEnable <= 1'b1;
		repeat (4) tk();
		chk(16'h0210, targetNow);
		@(posedge core_clk);
		outputSetpoint <= 16'h0238;
		repeat (50) tk();
		chk(16'h0248, targetGoal);
		chk(16'h0001, 16'(ramping));
		for (int i = 0; i < 200 && targetNow === 16'h0210; i++) tk();
		chk(16'h0215, targetNow);
		for (int i = 0; i < 1500 && targetNow !== 16'h0248; i++) tk();
		chk(16'h0248, targetNow);
		$display("test ramp done");
		@(posedge core_clk);
		outputSetpoint <= 16'h0600;
		for (int i = 0; i < 10 && limitWarnPulse !== 1'b1; i++) tk();
		chk(16'h0400, targetGoal);
		tk();
		chk(16'h000F, {12'h0, noneOfAboveSet, statusWordVoutSet,
			voutMaxMinWarnSet, alertRequest});
		@(posedge core_clk);
		alertClear <= 1'b1;
		@(posedge core_clk);
		alertClear <= 1'b0;
		tk();
		chk(16'h0000, 16'(alertRequest));
		marginSelect <= VLS_MARGIN_LOW;
		repeat (3) tk();
		chk(16'h0110, targetGoal);
		marginSelect <= VLS_MARGIN_HIGH;
		repeat (3) tk();
		chk(16'h0400, targetGoal);
		wr(8'h24, 16'h0300);
		for (int i = 0; i < 10 && limitWarnPulse !== 1'b1; i++) tk();
		chk(16'h0300, targetGoal);
		marginRelative <= 1'b1;
		outputSetpoint <= 16'h0100;
		marginSelect <= VLS_MARGIN_LOW;
		repeat (3) tk();
		chk(16'h0210, targetGoal);
		wr(8'h25, 16'h0500);
		#1 chk(16'h0000, 16'(invalidDataPulse));
		rd(8'h25, 16'h0500);
		@(posedge core_clk);
		conversionEnable <= 1'b0;
		repeat (4) tk();
		chk(16'h0000, targetNow);
		$display("test clamp_margin done");
		close_out();
	end
endmodule : tb_vls_limit_slew
